// [logic/itg_consts.vh]
// Function
// RQ1: as local master, scl high width set from 8-bit count of oscillator periods
// RQ2: scl high lasts count plus five oscillator periods
// RQ3: scl high count resets to 0x7f
// RQ4: scl low lasts count plus five oscillator periods
// RQ5: scl low count resets to 0x7f
// RQ6: as slave, scl low count sets sda setup before releasing stretched scl
// RQ7: remote forward bits route remote pin levels to local pins, reset 0xf
// RQ8: local output value drives pin when forwarding off and output enabled
// RQ9: per-pin output enables, one enables driver, reset to zero
// RQ10: per-pin input enables, one enables sampling, reset to one
// RQ11: forwarded remote level takes priority over local output value
`ifndef ITG_CONSTS_VH
`define ITG_CONSTS_VH
`define ITG_ADDR_W        4
`define ITG_OFF_SCL_HIGH  4'hb
`define ITG_OFF_SCL_LOW   4'hc
`define ITG_OFF_PIN_DATA  4'hd
`define ITG_OFF_PIN_DIR   4'he
`define ITG_OFF_RSVD      4'hf
`define ITG_OFF_STATUS    4'h0
`define ITG_RST_SCL_HIGH  8'h7f
`define ITG_RST_SCL_LOW   8'h7f
`define ITG_RST_FWD       4'hf
`define ITG_RST_OUTVAL    4'h0
`define ITG_RST_OUT_EN    4'h0
`define ITG_RST_IN_EN     4'hf
`define ITG_RST_RSVD      4'h0
`define ITG_EXTRA_PERIODS 9'h005
`define ITG_BAD_DATA      32'h00000000
`define ITG_BYTE_MSB      7
`define ITG_BYTE_LSB      0
`define ITG_HN_MSB        7
`define ITG_HN_LSB        4
`define ITG_LN_MSB        3
`define ITG_LN_LSB        0
`define ITG_BE_LANE0      0
`endif

// [logic/itg_period_timer.v]
`timescale 1ns/100ps
`include "itg_consts.vh"
// counts count plus five oscillator ticks after start, then pulses done
module itg_period_timer #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         rst,
    input  wire         tick,
    input  wire         start,
    input  wire [W-1:0] count,
    output reg          busy,
    output reg          done
);
    reg [W:0] cnt_reg;

    always @(posedge clk) begin
        if (rst) begin
            cnt_reg <= {(W+1){1'b0}};
            busy    <= 1'b0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                cnt_reg <= {1'b0, count} + `ITG_EXTRA_PERIODS; // RQ2 RQ4
                busy    <= 1'b1;
            end else if (busy && tick) begin
                if (cnt_reg <= {{W{1'b0}}, 1'b1}) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                cnt_reg <= cnt_reg - {{W{1'b0}}, 1'b1};
            end
        end
    end
endmodule // itg_period_timer

// [logic/itg_pin_cell.v]
`timescale 1ns/100ps
// one general-purpose pin: output mux and input gating
module itg_pin_cell (
    input  wire clk,
    input  wire rst,
    input  wire fwd_en,
    input  wire local_val,
    input  wire out_en,
    input  wire in_en,
    input  wire remote_val,
    input  wire pin_in,
    output reg  pin_out,
    output reg  pin_oe,
    output reg  pin_sample
);
    always @(posedge clk) begin
        if (rst) begin
            pin_out    <= 1'b0;
            pin_oe     <= 1'b0;
            pin_sample <= 1'b0;
        end else begin
            pin_oe     <= out_en;                              // RQ9
            pin_out    <= fwd_en ? remote_val : local_val;     // RQ7 RQ8 RQ11
            pin_sample <= in_en ? pin_in : 1'b0;               // RQ10
        end
    end
endmodule // itg_pin_cell

// [logic/itg_regs.v]
`timescale 1ns/100ps
`include "itg_consts.vh"
module itg_regs #(
    parameter NPINS = 4
) (
    input  wire             clk,
    input  wire             rst,
    input  wire [3:0]       avs_address,
    input  wire             avs_read,
    input  wire             avs_write,
    input  wire [31:0]      avs_writedata,
    input  wire [3:0]       avs_byteenable,
    output reg  [31:0]      avs_readdata,
    output reg              avs_waitrequest,
    input  wire             osc_tick,
    input  wire             scl_high_start,
    input  wire             scl_low_start,
    input  wire             sda_setup_start,
    output reg              scl_high_done,
    output reg              scl_low_done,
    output reg              sda_setup_done,
    input  wire [NPINS-1:0] remote_pin_in,
    input  wire [NPINS-1:0] pin_in,
    output reg  [NPINS-1:0] pin_out,
    output reg  [NPINS-1:0] pin_oe,
    output reg  [NPINS-1:0] pin_sample
);
    reg  [7:0]       scl_high_period_reg;
    reg  [7:0]       scl_low_period_reg;
    reg  [3:0]       remote_pin_forward_en_reg;
    reg  [3:0]       local_pin_out_value_reg;
    reg  [3:0]       pin_output_en_reg;
    reg  [3:0]       pin_input_en_reg;
    reg  [3:0]       reserved_0f_reg;
    reg              ack_reg;
    wire             req;
    wire             hi_busy;
    wire             lo_busy;
    wire             su_busy;
    wire             hi_done;
    wire             lo_done;
    wire             su_done;
    wire [NPINS-1:0] p_out;
    wire [NPINS-1:0] p_oe;
    wire [NPINS-1:0] p_smp;
    reg  [31:0]      rd_next;
    wire [7:0]       wr_byte;

    assign req = (avs_read | avs_write) & ~ack_reg;
    assign wr_byte = avs_writedata[`ITG_BYTE_MSB:`ITG_BYTE_LSB];

    always @* begin
        case (avs_address)
            `ITG_OFF_SCL_HIGH: rd_next = {24'h000000, scl_high_period_reg};
            `ITG_OFF_SCL_LOW:  rd_next = {24'h000000, scl_low_period_reg};
            `ITG_OFF_PIN_DATA: rd_next = {24'h000000,
                                   remote_pin_forward_en_reg,
                                   local_pin_out_value_reg};
            `ITG_OFF_PIN_DIR:  rd_next = {24'h000000, pin_output_en_reg,
                                   pin_input_en_reg};
            `ITG_OFF_RSVD:     rd_next = {28'h0000000, reserved_0f_reg};
            `ITG_OFF_STATUS:   rd_next = {24'h000000, 1'b0, su_busy,
                                   lo_busy, hi_busy, pin_sample};
            default:           rd_next = `ITG_BAD_DATA;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            scl_high_period_reg       <= `ITG_RST_SCL_HIGH;   // RQ3
            scl_low_period_reg        <= `ITG_RST_SCL_LOW;    // RQ5
            remote_pin_forward_en_reg <= `ITG_RST_FWD;        // RQ7
            local_pin_out_value_reg   <= `ITG_RST_OUTVAL;
            pin_output_en_reg         <= `ITG_RST_OUT_EN;     // RQ9
            pin_input_en_reg          <= `ITG_RST_IN_EN;      // RQ10
            reserved_0f_reg           <= `ITG_RST_RSVD;
            ack_reg                   <= 1'b0;
            avs_readdata              <= 32'h00000000;
            avs_waitrequest           <= 1'b1;
        end else begin
            ack_reg         <= req;
            avs_waitrequest <= ~req;
            if (req && avs_read)
                avs_readdata <= rd_next;
            if (req && avs_write && avs_byteenable[`ITG_BE_LANE0]) begin
                case (avs_address)
                    `ITG_OFF_SCL_HIGH:
                        scl_high_period_reg <= wr_byte; // RQ1
                    `ITG_OFF_SCL_LOW:
                        scl_low_period_reg <= wr_byte;
                    `ITG_OFF_PIN_DATA: begin
                        remote_pin_forward_en_reg <=
                            wr_byte[`ITG_HN_MSB:`ITG_HN_LSB];
                        local_pin_out_value_reg   <=
                            wr_byte[`ITG_LN_MSB:`ITG_LN_LSB];
                    end
                    `ITG_OFF_PIN_DIR: begin
                        pin_output_en_reg <= wr_byte[`ITG_HN_MSB:`ITG_HN_LSB];
                        pin_input_en_reg  <= wr_byte[`ITG_LN_MSB:`ITG_LN_LSB];
                    end
                    `ITG_OFF_RSVD:
                        reserved_0f_reg <= wr_byte[`ITG_LN_MSB:`ITG_LN_LSB];
                    default: ;
                endcase
            end
        end
    end

    itg_period_timer #(.W(8)) u_high (
        .clk   (clk),
        .rst   (rst),
        .tick  (osc_tick),
        .start (scl_high_start),
        .count (scl_high_period_reg), // RQ1 RQ2
        .busy  (hi_busy),
        .done  (hi_done)
    );

    itg_period_timer #(.W(8)) u_low (
        .clk   (clk),
        .rst   (rst),
        .tick  (osc_tick),
        .start (scl_low_start),
        .count (scl_low_period_reg), // RQ4
        .busy  (lo_busy),
        .done  (lo_done)
    );

    itg_period_timer #(.W(8)) u_setup (
        .clk   (clk),
        .rst   (rst),
        .tick  (osc_tick),
        .start (sda_setup_start),
        .count (scl_low_period_reg), // RQ6
        .busy  (su_busy),
        .done  (su_done)
    );

    genvar g;
    generate
        for (g = 0; g < NPINS; g = g + 1) begin : g_pin
            itg_pin_cell u_pin (
                .clk        (clk),
                .rst        (rst),
                .fwd_en     (remote_pin_forward_en_reg[g]),
                .local_val  (local_pin_out_value_reg[g]),
                .out_en     (pin_output_en_reg[g]),
                .in_en      (pin_input_en_reg[g]),
                .remote_val (remote_pin_in[g]),
                .pin_in     (pin_in[g]),
                .pin_out    (p_out[g]),
                .pin_oe     (p_oe[g]),
                .pin_sample (p_smp[g])
            );
        end
    endgenerate

    always @(posedge clk) begin
        if (rst) begin
            scl_high_done  <= 1'b0;
            scl_low_done   <= 1'b0;
            sda_setup_done <= 1'b0;
            pin_out        <= {NPINS{1'b0}};
            pin_oe         <= {NPINS{1'b0}};
            pin_sample     <= {NPINS{1'b0}};
        end else begin
            scl_high_done  <= hi_done;
            scl_low_done   <= lo_done;
            sda_setup_done <= su_done; // RQ6
            pin_out        <= p_out;
            pin_oe         <= p_oe;
            pin_sample     <= p_smp;
        end
    end
endmodule // itg_regs

// [tb/itg_remote.sv]
`timescale 1ns/100ps
// far side: remote pin levels and the oscillator tick, one tick per 2 cycles
module itg_remote (
    input  logic       clk,
    input  logic       rst,
    input  logic [3:0] lvl,
    output logic       osc_tick,
    output logic [3:0] remote_pin_in
);
    always @(posedge clk) begin
        osc_tick <= rst ? 1'b0 : ~osc_tick;
        remote_pin_in <= rst ? 4'h0 : lvl;
    end
endmodule // itg_remote

// [tb/itg_regs_chk.sv]
`timescale 1ns/100ps
module itg_regs_chk (
    input logic        clk,
    input logic        rst,
    input logic [3:0]  avs_address,
    input logic        avs_read,
    input logic        avs_write,
    input logic [31:0] avs_writedata,
    input logic [3:0]  avs_byteenable,
    input logic        avs_waitrequest,
    input logic [31:0] avs_readdata,
    input logic        osc_tick,
    input logic        scl_high_start,
    input logic        scl_low_start,
    input logic        sda_setup_start,
    input logic        scl_high_done,
    input logic        scl_low_done,
    input logic        sda_setup_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ticks seen since the last start, the start edge included
    reg  [9:0] hi_reg;
    reg  [9:0] lo_reg;
    reg  [9:0] su_reg;
    // counts programmed by accepted writes
    reg  [7:0] hi_cnt;
    reg  [7:0] lo_cnt;
    wire       wr_ok;
    assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    always @(posedge clk) begin
        if (rst) begin
            hi_reg <= 10'h000;
            lo_reg <= 10'h000;
            su_reg <= 10'h000;
            hi_cnt <= 8'h7f;
            lo_cnt <= 8'h7f;
        end else begin
            hi_reg <= scl_high_start ? {9'h000, osc_tick} : hi_reg + osc_tick;
            lo_reg <= scl_low_start ? {9'h000, osc_tick} : lo_reg + osc_tick;
            su_reg <= sda_setup_start ? {9'h000, osc_tick} : su_reg + osc_tick;
            if (wr_ok && avs_address == 4'hb)
                hi_cnt <= avs_writedata[7:0];
            if (wr_ok && avs_address == 4'hc)
                lo_cnt <= avs_writedata[7:0];
        end
    end
    property p_ack; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_ack: assert property (p_ack) else $error("long ack");
    property p_ans; $rose(avs_read | avs_write) |-> ##[1:3] !avs_waitrequest;
    endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_rdh; $changed(avs_readdata) |-> !avs_waitrequest; endproperty
    a_rdh: assert property (p_rdh) else $error("readdata moved");
    property p_hmin;
        scl_high_done |-> hi_reg >= hi_cnt + 10'd5 && hi_reg <= hi_cnt + 10'd7;
    endproperty
    a_hmin: assert property (p_hmin) else $error("high length off");
    property p_lmin;
        scl_low_done |-> lo_reg >= lo_cnt + 10'd5 && lo_reg <= lo_cnt + 10'd7;
    endproperty
    a_lmin: assert property (p_lmin) else $error("low length off");
    property p_smin;
        sda_setup_done |-> su_reg >= lo_cnt + 10'd5 && su_reg <= lo_cnt + 10'd7;
    endproperty
    a_smin: assert property (p_smin) else $error("setup length off");
    property p_hp; scl_high_done |=> !scl_high_done; endproperty
    a_hp: assert property (p_hp) else $error("high done stuck");
    property p_lp; scl_low_done |=> !scl_low_done; endproperty
    a_lp: assert property (p_lp) else $error("low done stuck");
    property p_sp; sda_setup_done |=> !sda_setup_done; endproperty
    a_sp: assert property (p_sp) else $error("setup done stuck");
    cover property (scl_high_done);
    cover property (scl_low_done);
    cover property (sda_setup_done);
endmodule // itg_regs_chk
bind itg_regs itg_regs_chk u_chk (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .osc_tick(osc_tick), .scl_high_start(scl_high_start),
    .scl_low_start(scl_low_start), .sda_setup_start(sda_setup_start),
    .scl_high_done(scl_high_done), .scl_low_done(scl_low_done),
    .sda_setup_done(sda_setup_done));

// [tb/itg_regs_tb_top.sv]
`timescale 1ns/100ps
module itg_regs_tb_top;
    reg         clk, rst, avs_read, avs_write;
    reg  [3:0]  avs_address, avs_byteenable, lvl, pin_in;
    reg  [31:0] avs_writedata, q;
    reg  [2:0]  st;
    reg  [7:0]  exp_reg [0:15];
    wire [31:0] avs_readdata;
    wire        avs_waitrequest, osc_tick, h_done, l_done, s_done;
    wire [3:0]  remote_pin_in, pin_out, pin_oe, pin_sample;
    integer     n_mismatch = 0, compares = 0, cyc = 0, seed = 32'h7ec4;
    integer     i, k, n, c, tk;
    itg_remote u_rem (.clk(clk), .rst(rst), .lvl(lvl), .osc_tick(osc_tick),
        .remote_pin_in(remote_pin_in));
    itg_regs dut (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .osc_tick(osc_tick), .scl_high_start(st[0]), .scl_low_start(st[1]),
        .sda_setup_start(st[2]), .scl_high_done(h_done),
        .scl_low_done(l_done), .sda_setup_done(s_done),
        .remote_pin_in(remote_pin_in), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_sample(pin_sample));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc > 20000) begin
            n_mismatch = n_mismatch + 1;
            end_of_test;
        end
    end
    // oscillator ticks seen before the current edge
    always @(posedge clk) tk <= rst ? 0 : tk + osc_tick;
    task chk(input [31:0] got, input [31:0] want);
        compares = compares + 1;
        if (got !== want) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task pinchk;
        chk(pin_oe, exp_reg[14][7:4]);
        chk(pin_sample, pin_in & exp_reg[14][3:0]);
        chk(pin_out, (exp_reg[13][7:4] & lvl) |
            (~exp_reg[13][7:4] & exp_reg[13][3:0]));
    endtask
    task end_of_test;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one avalon access; the model follows every accepted write
    task acc(input w, input [3:0] a, input [31:0] d, input [3:0] b);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= b;
        avs_read <= !w;
        avs_write <= w;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (w && b[0] && a > 4'ha) exp_reg[a] = d[7:0] & (a == 4'hf ? 15 : 255);
        @(posedge clk);
    endtask
    task rdall;
        for (i = 1; i < 16; i = i + 1) begin
            acc(1'b0, i[3:0], 32'h0, 4'hf);
            chk(q, {24'h0, exp_reg[i]});
        end
    endtask
    initial begin
        {rst, avs_read, avs_write, avs_address, avs_byteenable} = 11'h400;
        {avs_writedata, lvl, pin_in, st} = 0;
        for (i = 0; i < 16; i = i + 1) exp_reg[i] = 8'h00;
        {exp_reg[11], exp_reg[12], exp_reg[13], exp_reg[14]} = 32'h7f7ff00f;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdall;
        for (k = 0; k < 12; k = k + 1) begin
            c = {$random(seed)} % 15 + 1;
            n = $random(seed);
            acc(1'b1, c[3:0], $random(seed), n[3:0]);
        end
        rdall;
        for (k = 0; k < 16; k = k + 1) begin
            n = $random(seed);
            lvl <= n[11:8];
            pin_in <= n[15:12];
            acc(1'b1, 4'hd, n[7:0], 4'h1);
            acc(1'b1, 4'he, n[23:16], 4'h1);
            repeat (4) @(posedge clk);
            pinchk;
            acc(1'b0, 4'h0, 32'h0, 4'hf);
            chk(q, {28'h0, pin_in & exp_reg[14][3:0]});
        end
        for (k = 0; k < 3; k = k + 1) begin
            c = {$random(seed)} % 8;
            acc(1'b1, k ? 4'hc : 4'hb, c, 4'h1);
            st <= 3'b001 << k;
            @(posedge clk);
            st <= 3'b000;
            n = tk;
            acc(1'b0, 4'h0, 32'h0, 4'hf);
            chk(q[6:4], 3'b001 << k);
            i = 0;
            while ({s_done, l_done, h_done} !== (3'b001 << k) && i < 600) begin
                @(posedge clk);
                i = i + 1;
            end
            chk(tk - n >= c + 5 && tk - n <= c + 7, 1);
        end
        // reset in mid-run brings every register back to its reset value
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        {exp_reg[11], exp_reg[12], exp_reg[13], exp_reg[14]} = 32'h7f7ff00f;
        exp_reg[15] = 8'h00;
        @(posedge clk);
        rdall;
        pinchk;
        end_of_test;
    end
endmodule // itg_regs_tb_top
